// >>> rtl/ubd_ctrl.sv
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "ubd_map.svh"

// How it works
// - Count is high bits joined with low byte
// - IN sends count; OUT accepts up to count
// - Toggle checked only when check enable set
// - Engine obeys core settings once it owns descriptor
// - Wrong toggle: ACK, drop data, keep ownership
// - Keep-owned: hold descriptor, no queue, no interrupt
// - Address-step inhibit keeps every byte at base
// - Stall: answer STALL until SETUP returns ownership
module ubd_ctrl
  import ubd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic        tok_valid_i,
  input  wire logic [3:0]  tok_pid_i,
  input  wire logic        rx_pid_valid_i,
  input  wire logic        rx_toggle_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_end_i,
  input  wire logic        rx_err_i,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_data_o,
  input  wire logic        tx_ready_i,
  output logic             tx_end_o,
  output logic             hs_valid_o,
  output logic      [1:0]  hs_code_o,
  output logic             tsq_push_o,
  output logic      [7:0]  tsq_entry_o
);

  ubd_mem_if mif ();

  ubd_mem u_mem (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .mp    (mif.mem)
  );

  logic [7:0]  stat_reg, stat_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic [9:0]  addr_reg, addr_next;
  logic [1:0]  ep_reg, ep_next;
  logic [2:0]  ist_reg, ist_next;
  logic [2:0]  imsk_reg, imsk_next;
  logic [7:0]  tsq_reg, tsq_next;
  logic        ack_reg;
  logic [31:0] dat_reg, dat_next;
  logic        mrd_reg, mrd_next;
  ubd_state_t  st_reg, st_next;
  logic [9:0]  nb_reg, nb_next;
  logic [3:0]  pid_reg, pid_next;
  logic        drop_reg, drop_next;
  logic        ovf_reg, ovf_next;
  logic        hsv_reg, hsv_next;
  ubd_hs_t     hsc_reg, hsc_next;
  logic        tsqp_reg, tsqp_next;
  logic        txe_reg, txe_next;
  logic        fin_ok;
  logic [2:0]  ev;

  logic        req;
  logic        buf_sel;
  logic [9:0]  cur_count;
  logic        owner;
  logic        keep;
  ubd_tok_t    tk;
  logic        tok_go;

  assign req       = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign buf_sel   = (wb_adr_i[15:12] == `UBD_BUF_PAGE);
  assign cur_count = {stat_reg[`UBD_B_CNTH], cnt_reg};
  assign owner     = stat_reg[`UBD_B_OWNER];
  assign keep      = stat_reg[`UBD_B_KEEP];
  assign tk        = ubd_tok_kind(tok_pid_i);
  // Tokens count only on an enabled endpoint and when the engine is idle
  assign tok_go    = tok_valid_i & ep_reg[`UBD_B_EPEN]
                   & (tk != UBD_TK_NONE) & (st_reg == UBD_IDLE);

  assign mif.a_we    = req & wb_we_i & wb_sel_i[0] & buf_sel;
  assign mif.a_addr  = wb_adr_i[11:2];
  assign mif.a_wdata = wb_dat_i[7:0];
  // Inhibited stepping pins every byte at the base address
  assign mif.b_addr  = stat_reg[`UBD_B_INHIB] ? addr_reg
                                              : addr_reg + nb_reg;
  assign mif.b_wdata = rx_data_i;
  // Dropped packets and bytes beyond the count never reach the buffer
  assign mif.b_we    = (st_reg == UBD_RX_DATA) & rx_valid_i & ~drop_reg
                     & (nb_reg != cur_count);

  always_comb
  begin
    stat_next = stat_reg;
    cnt_next  = cnt_reg;
    addr_next = addr_reg;
    ep_next   = ep_reg;
    imsk_next = imsk_reg;
    tsq_next  = tsq_reg;
    dat_next  = dat_reg;
    mrd_next  = 1'b0;
    st_next   = st_reg;
    nb_next   = nb_reg;
    pid_next  = pid_reg;
    drop_next = drop_reg;
    ovf_next  = ovf_reg;
    hsv_next  = 1'b0;
    hsc_next  = hsc_reg;
    tsqp_next = 1'b0;
    txe_next  = 1'b0;
    fin_ok    = 1'b0;
    ev        = 3'h0;
    ist_next  = ist_reg;
    if (req)
    begin
      mrd_next = buf_sel;
      dat_next = 32'h0;
      case (wb_adr_i)
        `UBD_OFS_STAT:
        begin
          dat_next = {24'h0, stat_reg};
          if (wb_we_i && wb_sel_i[0])
            stat_next = wb_dat_i[7:0];
        end
        `UBD_OFS_CNT:
        begin
          dat_next = {24'h0, cnt_reg};
          if (wb_we_i && wb_sel_i[0])
            cnt_next = wb_dat_i[7:0];
        end
        `UBD_OFS_ADDR:
        begin
          dat_next = {22'h0, addr_reg};
          if (wb_we_i && wb_sel_i[0])
            addr_next[7:0] = wb_dat_i[7:0];
          if (wb_we_i && wb_sel_i[1])
            addr_next[9:8] = wb_dat_i[9:8];
        end
        `UBD_OFS_EPCTL:
        begin
          dat_next = {30'h0, ep_reg};
          if (wb_we_i && wb_sel_i[0])
            ep_next = wb_dat_i[1:0];
        end
        `UBD_OFS_IST:
        begin
          dat_next = {29'h0, ist_reg};
          if (!wb_we_i)
            ist_next = 3'h0;
        end
        `UBD_OFS_IMSK:
        begin
          dat_next = {29'h0, imsk_reg};
          if (wb_we_i && wb_sel_i[0])
            imsk_next = wb_dat_i[2:0];
        end
        `UBD_OFS_TSQ:
          dat_next = {24'h0, tsq_reg};
        default:
          dat_next = 32'h0;
      endcase
    end
    // Engine updates override a bus write in the same cycle
    unique case (st_reg)
      UBD_IDLE:
        if (tok_go)
        begin
          pid_next  = tok_pid_i;
          nb_next   = 10'h000;
          drop_next = 1'b0;
          ovf_next  = 1'b0;
          if (!owner)
          begin
            hsv_next = 1'b1;
            hsc_next = UBD_HS_NAK;
          end
          else if (stat_reg[`UBD_B_STALL])
          begin
            if (tk == UBD_TK_SETUP)
            begin
              stat_next[`UBD_B_OWNER] = 1'b0;
              stat_next[`UBD_B_STALL] = 1'b0;
            end
            else
            begin
              hsv_next = 1'b1;
              hsc_next = UBD_HS_STALL;
              ep_next[`UBD_B_EP_STALL] = 1'b1;
              ev[`UBD_I_STALL] = 1'b1;
            end
          end
          else if (tk == UBD_TK_IN)
            st_next = (cur_count == 10'h000) ? UBD_TX_END
                                             : UBD_TX_FETCH;
          else
            st_next = UBD_RX_WAIT;
        end
      UBD_TX_FETCH:
        st_next = UBD_TX_SEND;
      UBD_TX_SEND:
        if (tx_ready_i)
        begin
          nb_next = nb_reg + 10'h001;
          st_next = (nb_next == cur_count) ? UBD_TX_END
                                           : UBD_TX_FETCH;
        end
      UBD_TX_END:
      begin
        txe_next = 1'b1;
        fin_ok   = 1'b1;
        st_next  = UBD_IDLE;
      end
      UBD_RX_WAIT:
        if (rx_pid_valid_i)
        begin
          drop_next = stat_reg[`UBD_B_TCHK]
                    & (rx_toggle_i != stat_reg[`UBD_B_TOGGLE]);
          st_next = UBD_RX_DATA;
        end
        else if (rx_end_i)
        begin
          hsv_next = 1'b1;
          hsc_next = UBD_HS_NAK;
          ev[`UBD_I_ERR] = 1'b1;
          st_next = UBD_IDLE;
        end
      UBD_RX_DATA:
      begin
        if (rx_valid_i)
        begin
          if (nb_reg == cur_count)
            ovf_next = 1'b1;
          else
            nb_next = nb_reg + 10'h001;
        end
        if (rx_end_i)
        begin
          hsv_next = 1'b1;
          st_next  = UBD_IDLE;
          if (rx_err_i || ovf_next)
          begin
            hsc_next = UBD_HS_NAK;
            ev[`UBD_I_ERR] = 1'b1;
          end
          else
          begin
            hsc_next = UBD_HS_ACK;
            fin_ok   = ~drop_reg;
          end
        end
      end
      default:
        st_next = UBD_IDLE;
    endcase
    if (fin_ok)
    begin
      cnt_next = nb_next[7:0];
      stat_next[`UBD_B_CNTH] = nb_next[9:8];
      if (!keep)
      begin
        stat_next = {1'b0, stat_reg[`UBD_B_TOGGLE], pid_reg,
                     nb_next[9:8]};
        ev[`UBD_I_DONE] = 1'b1;
        tsqp_next = 1'b1;
        tsq_next  = {pid_reg, 4'h0};
      end
    end
    ist_next = ist_next | ev;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_reg <= `UBD_RST_STAT;
      cnt_reg  <= `UBD_RST_CNT;
      addr_reg <= `UBD_RST_ADDR;
      ep_reg   <= `UBD_RST_EP;
      ist_reg  <= `UBD_RST_IRQ;
      imsk_reg <= `UBD_RST_IRQ;
      tsq_reg  <= `UBD_RST_TSQ;
      ack_reg  <= 1'b0;
      dat_reg  <= 32'h0;
      mrd_reg  <= 1'b0;
      st_reg   <= UBD_IDLE;
      nb_reg   <= 10'h000;
      pid_reg  <= 4'h0;
      drop_reg <= 1'b0;
      ovf_reg  <= 1'b0;
      hsv_reg  <= 1'b0;
      hsc_reg  <= UBD_HS_ACK;
      tsqp_reg <= 1'b0;
      txe_reg  <= 1'b0;
    end
    else
    begin
      stat_reg <= stat_next;
      cnt_reg  <= cnt_next;
      addr_reg <= addr_next;
      ep_reg   <= ep_next;
      ist_reg  <= ist_next;
      imsk_reg <= imsk_next;
      tsq_reg  <= tsq_next;
      ack_reg  <= req;
      dat_reg  <= dat_next;
      mrd_reg  <= mrd_next;
      st_reg   <= st_next;
      nb_reg   <= nb_next;
      pid_reg  <= pid_next;
      drop_reg <= drop_next;
      ovf_reg  <= ovf_next;
      hsv_reg  <= hsv_next;
      hsc_reg  <= hsc_next;
      tsqp_reg <= tsqp_next;
      txe_reg  <= txe_next;
    end
  end

  assign wb_ack_o    = ack_reg;
  assign wb_dat_o    = mrd_reg ? {24'h0, mif.a_rdata} : dat_reg;
  assign irq_o       = |(ist_reg & imsk_reg);
  assign tx_valid_o  = (st_reg == UBD_TX_SEND);
  assign tx_data_o   = mif.b_rdata;
  assign tx_end_o    = txe_reg;
  assign hs_valid_o  = hsv_reg;
  assign hs_code_o   = hsc_reg;
  assign tsq_push_o  = tsqp_reg;
  assign tsq_entry_o = tsq_reg;

  a_in_count: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_end_o |-> nb_reg == $past(cur_count))
    else $error("IN packet ended before count bytes were sent");

  a_out_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    mif.b_we |-> nb_reg < cur_count)
    else $error("OUT byte written beyond the byte count");

  a_count_join: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == UBD_RX_DATA && rx_end_i && !rx_err_i && !ovf_next
     && !drop_reg && !rx_valid_i)
    |=> {stat_reg[1:0], cnt_reg} == $past(nb_reg))
    else $error("Received count not stored across both count fields");

  a_toggle_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == UBD_RX_WAIT && rx_pid_valid_i && !stat_reg[3])
    |=> !drop_reg)
    else $error("Toggle compared while checking is disabled");

  a_bad_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == UBD_RX_DATA && drop_reg && rx_end_i && !rx_err_i
     && !ovf_next)
    |=> hs_valid_o && hs_code_o == UBD_HS_ACK && owner && !tsq_push_o
        && !$rose(ist_reg[0]))
    else $error("Wrong toggle packet not acked and held");

  a_keep_owned: assert property (@(posedge clk_i) disable iff (rst_i)
    (fin_ok && keep && !req) |=> owner && !tsq_push_o)
    else $error("Keep-owned descriptor was released or posted");

  a_inhib_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    (stat_reg[4] && mif.b_we) |-> mif.b_addr == addr_reg)
    else $error("Buffer address stepped while inhibited");

  a_stall_resp: assert property (@(posedge clk_i) disable iff (rst_i)
    (tok_go && owner && stat_reg[2] && tk != UBD_TK_SETUP)
    |=> hs_valid_o && hs_code_o == UBD_HS_STALL && ep_reg[1] && ist_reg[1]
        ##1 !hs_valid_o)
    else $error("Stalled descriptor did not answer with STALL");

  a_setup_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (tok_go && owner && stat_reg[2] && tk == UBD_TK_SETUP && !req)
    |=> !owner && !stat_reg[2] && !hs_valid_o)
    else $error("SETUP did not clear stall and return ownership");

  a_core_owned: assert property (@(posedge clk_i) disable iff (rst_i)
    (tok_go && !owner) |=> hs_valid_o && hs_code_o == UBD_HS_NAK
        && st_reg == UBD_IDLE)
    else $error("Core-owned descriptor was served");

endmodule

// >>> rtl/ubd_mem.sv
`timescale 1ns/1ns

// Endpoint buffer: port a for the bus, port b for the engine
module ubd_mem
  import ubd_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  ubd_mem_if.mem    mp
);

  logic [7:0] ram [0:1023];
  logic [7:0] a_q;
  logic [7:0] b_q;

  always_ff @(posedge clk_i)
  begin
    if (mp.a_we)
      ram[mp.a_addr] <= mp.a_wdata;
    if (mp.b_we)
      ram[mp.b_addr] <= mp.b_wdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      a_q <= 8'h00;
      b_q <= 8'h00;
    end
    else
    begin
      a_q <= ram[mp.a_addr];
      b_q <= ram[mp.b_addr];
    end
  end

  assign mp.a_rdata = a_q;
  assign mp.b_rdata = b_q;

endmodule

// >>> shared/ubd_map.svh
`ifndef UBD_MAP_SVH
`define UBD_MAP_SVH

// Register byte offsets on the bus
`define UBD_OFS_STAT  16'h0000
`define UBD_OFS_CNT   16'h0004
`define UBD_OFS_ADDR  16'h0008
`define UBD_OFS_EPCTL 16'h000c
`define UBD_OFS_IST   16'h0010
`define UBD_OFS_IMSK  16'h0014
`define UBD_OFS_TSQ   16'h0018
// Buffer window: address bits 15:12 equal to this page, one byte per word
`define UBD_BUF_PAGE  4'h1

// Descriptor status byte fields (core view)
`define UBD_B_OWNER   7
`define UBD_B_TOGGLE  6
`define UBD_B_KEEP    5
`define UBD_B_INHIB   4
`define UBD_B_TCHK    3
`define UBD_B_STALL   2
`define UBD_B_CNTH    1:0

// Endpoint control fields
`define UBD_B_EPEN    0
`define UBD_B_EP_STALL 1

// Interrupt status and mask fields
`define UBD_I_DONE    0
`define UBD_I_STALL   1
`define UBD_I_ERR     2

// Reset values
`define UBD_RST_STAT  8'h00
`define UBD_RST_CNT   8'h00
`define UBD_RST_ADDR  10'h000
`define UBD_RST_EP    2'h0
`define UBD_RST_IRQ   3'h0
`define UBD_RST_TSQ   8'h00

// Token packet identifiers
`define UBD_PID_OUT   4'h1
`define UBD_PID_IN    4'h9
`define UBD_PID_SETUP 4'hd

`endif

// >>> shared/ubd_mem_if.sv
`timescale 1ns/1ns

interface ubd_mem_if;
  logic       a_we;
  logic [9:0] a_addr;
  logic [7:0] a_wdata;
  logic [7:0] a_rdata;
  logic       b_we;
  logic [9:0] b_addr;
  logic [7:0] b_wdata;
  logic [7:0] b_rdata;

  modport ctrl (
    output a_we, a_addr, a_wdata, b_we, b_addr, b_wdata,
    input  a_rdata, b_rdata
  );
  modport mem (
    input  a_we, a_addr, a_wdata, b_we, b_addr, b_wdata,
    output a_rdata, b_rdata
  );
endinterface

// >>> shared/ubd_pkg.sv
`include "ubd_map.svh"

package ubd_pkg;

  typedef enum logic [2:0] {
    UBD_IDLE, UBD_TX_FETCH, UBD_TX_SEND, UBD_TX_END, UBD_RX_WAIT, UBD_RX_DATA
  } ubd_state_t;

  typedef enum logic [1:0] {UBD_HS_ACK, UBD_HS_NAK, UBD_HS_STALL} ubd_hs_t;

  typedef enum logic [1:0] {
    UBD_TK_NONE, UBD_TK_OUT, UBD_TK_IN, UBD_TK_SETUP
  } ubd_tok_t;

  function automatic ubd_tok_t ubd_tok_kind(input logic [3:0] pid);
    ubd_tok_t k;
    k = UBD_TK_NONE;
    if (pid == `UBD_PID_OUT)
      k = UBD_TK_OUT;
    else if (pid == `UBD_PID_IN)
      k = UBD_TK_IN;
    else if (pid == `UBD_PID_SETUP)
      k = UBD_TK_SETUP;
    return k;
  endfunction

endpackage

// >>> tb/tb.sv
`timescale 1ns/1ns
`include "ubd_map.svh"

module tb
  import ubd_pkg::*;
;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [15:0] adr;
  logic [31:0] dw;
  logic [31:0] dr;
  logic        ack;
  logic        irq;
  logic        tv, pv, tg, xv, xe, xr, txv, txr, txe, hsv, tp;
  logic [3:0]  pid;
  logic [7:0]  xd;
  logic [7:0]  td;
  logic [1:0]  hsc;
  logic [7:0]  te;
  logic [7:0]  tsq_last;
  logic [7:0]  ib[257];
  int          bad_count;
  int          cmp_count;
  int          hs_n;
  int          tsq_n;

  ubd_ctrl uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .irq_o(irq), .tok_valid_i(tv),
    .tok_pid_i(pid), .rx_pid_valid_i(pv), .rx_toggle_i(tg),
    .rx_valid_i(xv), .rx_data_i(xd), .rx_end_i(xe), .rx_err_i(xr),
    .tx_valid_o(txv), .tx_data_o(td), .tx_ready_i(txr), .tx_end_o(txe),
    .hs_valid_o(hsv), .hs_code_o(hsc), .tsq_push_o(tp), .tsq_entry_o(te)
  );

  ubd_host host (
    .clk_i(clk_i), .tx_valid_i(txv), .tx_data_i(td), .tok_valid_o(tv),
    .tok_pid_o(pid), .rx_pid_valid_o(pv), .rx_toggle_o(tg),
    .rx_valid_o(xv), .rx_data_o(xd), .rx_end_o(xe), .rx_err_o(xr),
    .tx_ready_o(txr)
  );

  always #25 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    if (hsv === 1'b1)
      hs_n++;
    if (tp === 1'b1)
    begin
      tsq_n++;
      tsq_last <= te;
    end
  end

  task automatic stop_test;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [15:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dw  <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && t < 20)
    begin
      t++;
      @(posedge clk_i);
    end
    if (ack !== 1'b1)
      chk(32'h0, 32'h1, "bus ack timeout");
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [15:0] a, input logic [31:0] e,
                      input logic [31:0] k = 32'hffffffff);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & k, e, "register");
  endtask

  task automatic hs_chk(input logic [1:0] e);
    int t;
    t = 0;
    while (hsv !== 1'b1 && t < 40)
    begin
      t++;
      @(posedge clk_i);
    end
    chk({29'h0, hsv, hsc}, {29'h0, 1'b1, e}, "handshake");
  endtask

  task automatic fill(input int n);
    for (int i = 0; i < n; i++)
      host.bytes[i] = 8'($urandom);
  endtask

  // Status byte written last, so the descriptor is armed complete
  task automatic out_run(input logic [7:0] st, input logic [7:0] cl,
                         input int n, input logic t, input logic [1:0] h);
    wr(`UBD_OFS_CNT, {24'h0, cl});
    wr(`UBD_OFS_STAT, {24'h0, st});
    host.token(`UBD_PID_OUT);
    host.data(t, n, 1'b0);
    hs_chk(h);
  endtask

  // Status after completion: owner clear, token code, count high bits
  function automatic logic [31:0] done_stat(input logic [3:0] p,
                                            input logic [9:0] c);
    return {24'h0, 2'b00, p, c[9:8]};
  endfunction

  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("FAIL %0t watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    logic [7:0]  b0;
    int          n0;
    int          t;
    logic [15:0] ofs[6];
    ofs = '{16'h0, 16'h4, 16'hc, 16'h10, 16'h18, 16'h20};
    {clk_i, cyc, stb, we, adr, dw, rst_i} = 53'h1;
    void'($urandom(32'h71382764));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ofs[i]) rchk(ofs[i], 32'h0);
    wr(16'h0020, 32'hffffffff);
    rchk(16'h0020, 32'h0);
    $display("test reset done");
    wr(`UBD_OFS_ADDR, 32'h10);
    wr(`UBD_OFS_IMSK, 32'h7);
    wr(`UBD_OFS_STAT, 32'h0);
    wr(`UBD_OFS_EPCTL, 32'h1);
    host.token(`UBD_PID_OUT);
    hs_chk(UBD_HS_NAK);
    fill(3);
    out_run(8'h88, 8'h04, 3, 1'b0, UBD_HS_ACK);
    rchk(`UBD_OFS_STAT, done_stat(`UBD_PID_OUT, 10'd3), 32'hbf);
    rchk(`UBD_OFS_CNT, 32'h3);
    for (int i = 0; i < 3; i++)
      rchk(16'h1040 + 16'(4 * i), {24'h0, host.bytes[i]});
    chk({31'h0, irq}, 32'h1, "irq raised");
    rchk(`UBD_OFS_IST, 32'h1);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    chk({24'h0, tsq_last}, 32'h10, "queue entry");
    $display("test out_toggle_ok done");
    n0 = tsq_n;
    b0 = host.bytes[0];
    fill(2);
    host.bytes[0] = ~b0;
    out_run(8'hc8, 8'h04, 2, 1'b0, UBD_HS_ACK);
    rchk(`UBD_OFS_STAT, 32'hc8);
    rchk(`UBD_OFS_IST, 32'h0);
    rchk(16'h1040, {24'h0, b0});
    chk(tsq_n, n0, "queue quiet");
    fill(2);
    out_run(8'hc0, 8'h04, 2, 1'b0, UBD_HS_ACK);
    rchk(`UBD_OFS_STAT, done_stat(`UBD_PID_OUT, 10'd2), 32'hbf);
    rchk(`UBD_OFS_IST, 32'h1);
    $display("test toggle done");
    fill(3);
    out_run(8'h80, 8'h02, 3, 1'b0, UBD_HS_NAK);
    rchk(`UBD_OFS_CNT, 32'h2);
    rchk(`UBD_OFS_IST, 32'h4);
    fill(1);
    host.token(`UBD_PID_OUT);
    host.data(1'b0, 1, 1'b1);
    hs_chk(UBD_HS_NAK);
    rchk(`UBD_OFS_STAT, 32'h80);
    rchk(`UBD_OFS_IST, 32'h4);
    wr(16'h1044, 32'ha5);
    fill(3);
    host.bytes[1] = 8'h5a;
    out_run(8'h91, 8'h00, 3, 1'b0, UBD_HS_ACK);
    rchk(16'h1040, {24'h0, host.bytes[2]});
    rchk(16'h1044, 32'ha5);
    rchk(`UBD_OFS_CNT, 32'h3);
    rchk(`UBD_OFS_IST, 32'h1);
    $display("test overflow_inhibit done");
    n0 = tsq_n;
    fill(1);
    out_run(8'ha0, 8'h04, 1, 1'b0, UBD_HS_ACK);
    rchk(`UBD_OFS_STAT, 32'ha0);
    rchk(`UBD_OFS_CNT, 32'h1);
    rchk(`UBD_OFS_IST, 32'h0);
    chk(tsq_n, n0, "keep queue");
    $display("test keep done");
    wr(`UBD_OFS_IMSK, 32'h0);
    wr(`UBD_OFS_STAT, 32'h84);
    host.token(`UBD_PID_IN);
    hs_chk(UBD_HS_STALL);
    chk({31'h0, irq}, 32'h0, "irq masked");
    rchk(`UBD_OFS_EPCTL, 32'h3);
    wr(`UBD_OFS_IMSK, 32'h7);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    rchk(`UBD_OFS_IST, 32'h2);
    n0 = hs_n;
    host.token(`UBD_PID_SETUP);
    repeat (3) @(posedge clk_i);
    rchk(`UBD_OFS_STAT, 32'h0, 32'h84);
    chk(hs_n, n0, "setup silent");
    wr(`UBD_OFS_EPCTL, 32'h1);
    $display("test stall done");
    for (int i = 0; i < 257; i++)
    begin
      ib[i] = 8'($urandom);
      wr(16'h1040 + 16'(4 * i), {24'h0, ib[i]});
    end
    wr(`UBD_OFS_CNT, 32'h01);
    wr(`UBD_OFS_STAT, 32'h81);
    host.slow = 1'b1;
    host.got_q.delete();
    host.token(`UBD_PID_IN);
    t = 0;
    while (txe !== 1'b1 && t < 3000)
    begin
      t++;
      @(posedge clk_i);
    end
    chk({31'h0, txe}, 32'h1, "in end");
    @(posedge clk_i);
    chk(host.got_q.size(), 257, "in length");
    for (int i = 0; i < 257 && i < host.got_q.size(); i++)
      chk({24'h0, host.got_q[i]}, {24'h0, ib[i]}, "in byte");
    rchk(`UBD_OFS_STAT, done_stat(`UBD_PID_IN, 10'd257), 32'hbf);
    rchk(`UBD_OFS_TSQ, 32'h90);
    rchk(`UBD_OFS_IST, 32'h1);
    wr(`UBD_OFS_CNT, 32'h0);
    wr(`UBD_OFS_STAT, 32'h80);
    host.got_q.delete();
    n0 = tsq_n;
    host.token(`UBD_PID_IN);
    repeat (4) @(posedge clk_i);
    chk(host.got_q.size(), 0, "zero length");
    chk(tsq_n, n0 + 1, "zero length done");
    rchk(`UBD_OFS_STAT, done_stat(`UBD_PID_IN, 10'd0), 32'hbf);
    $display("test in_long done");
    stop_test();
  end
endmodule

// >>> tb/ubd_host.sv
`timescale 1ns/1ns

// Host side of the link: sends tokens and data, takes IN bytes
module ubd_host
(
  input  wire logic       clk_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tok_valid_o,
  output logic [3:0]      tok_pid_o,
  output logic            rx_pid_valid_o,
  output logic            rx_toggle_o,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_end_o,
  output logic            rx_err_o,
  output logic            tx_ready_o
);
  logic       slow;
  logic [7:0] bytes[1024];
  logic [7:0] got_q[$];

  initial
  begin
    slow = 1'b0;
    {tok_valid_o, rx_pid_valid_o, rx_valid_o, rx_end_o} = 4'h0;
    {tok_pid_o, rx_toggle_o, rx_data_o, rx_err_o} = 14'h0;
    tx_ready_o = 1'b0;
  end

  // Slow mode stalls the engine on random cycles
  always @(posedge clk_i)
  begin
    tx_ready_o <= slow ? 1'($urandom) : 1'b1;
    if (tx_valid_i && tx_ready_o)
      got_q.push_back(tx_data_i);
  end

  // Idle lines show the inverse of the last value, never a stale copy
  task automatic token(input logic [3:0] pid);
    tok_valid_o <= 1'b1;
    tok_pid_o   <= pid;
    @(posedge clk_i);
    tok_valid_o <= 1'b0;
    tok_pid_o   <= ~pid;
  endtask

  task automatic data(input logic tgl, input int n, input logic err);
    rx_pid_valid_o <= 1'b1;
    rx_toggle_o    <= tgl;
    @(posedge clk_i);
    rx_pid_valid_o <= 1'b0;
    rx_toggle_o    <= ~tgl;
    for (int i = 0; i < n; i++)
    begin
      rx_valid_o <= 1'b1;
      rx_data_o  <= bytes[i];
      @(posedge clk_i);
    end
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~rx_data_o;
    rx_end_o   <= 1'b1;
    rx_err_o   <= err;
    @(posedge clk_i);
    rx_end_o <= 1'b0;
    rx_err_o <= ~err;
  endtask
endmodule
